//--- pfe_pkg.sv
package pfe_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_TIMER = 8'h04;
  localparam logic [7:0] ADDR_TBASE = 8'h08;
  localparam logic [7:0] ADDR_GLOBAL = 8'h0C;
  localparam logic [7:0] ADDR_EV_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EV_CLEAR = 8'h14;
  localparam logic [7:0] ADDR_EV_ENABLE = 8'h18;
  localparam int ADDR_W = 8;
  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [9:0] RST_SRC = 10'h000;
  // bit positions
  localparam int TB_IMPL_MASK_LO = 0;
  localparam logic [7:0] TB_IMPL_MASK = 8'h77; // bits 7 and 3 absent
  localparam int GLOBAL_EN_BIT = 0;
  localparam int NUM_SRC = 10;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // source indices, lowest index has highest priority
  localparam logic [3:0] SRC_EEPROM = 4'h0;
  localparam logic [3:0] SRC_ADC = 4'h1;
  localparam logic [3:0] SRC_LOW_VOLT = 4'h2;
  localparam logic [3:0] SRC_SERIAL = 4'h3;
  localparam logic [3:0] SRC_STD_A = 4'h4;
  localparam logic [3:0] SRC_STD_P = 4'h5;
  localparam logic [3:0] SRC_PER_A = 4'h6;
  localparam logic [3:0] SRC_PER_P = 4'h7;
  localparam logic [3:0] SRC_TB_ZERO = 4'h8;
  localparam logic [3:0] SRC_TB_ONE = 4'h9;

  // request toward the processor core
  typedef struct packed {
    logic req;
    logic [3:0] src;
  } pfe_core_req_type;

  // service acknowledge from the processor core
  typedef struct packed {
    logic ack;
    logic [3:0] src;
  } pfe_core_ack_type;
endpackage : pfe_pkg

//--- pfe_irq_flags.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bit 7 reg a: eeprom flag, writable
// - bit 0 reg a: serial module enable
// - bit 7 reg b: std timer A flag
// - bit 5 reg b: periodic timer A flag
// - bit 3 reg b: std timer A enable
// - bit 2 reg b: std timer P enable
// - bit 1 reg b: periodic timer A enable
// - bit 0 reg b: periodic timer P enable
// - bit 5 reg c: time base one flag
// - bit 4 reg c: time base zero flag
// - bit 1 reg c: time base one enable
// - bit 0 reg c: time base zero enable
// - reg c bits 7,3 read zero
// - disabled source keeps flag, no request
// - global enable low blocks every request
// - service clears global enable, flags still record
// - any newly set flag wakes the core
module pfe_irq_flags
  import pfe_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // one-cycle event pulses, one per source index
  input wire logic [NUM_SRC-1:0] src_event,
  // processor core side
  output pfe_core_req_type core_req,
  input wire pfe_core_ack_type core_ack,
  output logic wake,
  // event summary interrupt
  output logic irq
);

  // four sources packed into the flag nibble of an 8-bit register
  function automatic logic [7:0] nib_mask(input logic [3:0] v);
    nib_mask = {v[0], v[1], v[2], v[3], 4'h0};
  endfunction : nib_mask

  function automatic logic [NUM_SRC-1:0] onehot(input logic [3:0] idx);
    onehot = NUM_SRC'(10'h001 << idx);
  endfunction : onehot

  logic [7:0] ctrl_a_r, timer_r, tbase_r;
  logic [7:0] ctrl_a_nxt, timer_nxt, tbase_nxt;
  logic gie_r;
  logic [NUM_SRC-1:0] ev_status_r, ev_enable_r;
  logic [NUM_SRC-1:0] flags, enables, pend, svc_clr;
  logic [7:0] set_a, set_b, set_c, clr_a, clr_b, clr_c;
  logic aw_held_r, w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic wr_go;
  logic wr_a, wr_b, wr_c, wr_g, wr_clr, wr_en;
  logic wake_r;
  pfe_core_req_type core_req_r;

  // flag and enable views in source order
  assign flags = {tbase_r[5], tbase_r[4], timer_r[4], timer_r[5],
                  timer_r[6], timer_r[7], ctrl_a_r[4], ctrl_a_r[5],
                  ctrl_a_r[6], ctrl_a_r[7]};
  assign enables = {tbase_r[1], tbase_r[0], timer_r[0], timer_r[1],
                    timer_r[2], timer_r[3], ctrl_a_r[0], ctrl_a_r[1],
                    ctrl_a_r[2], ctrl_a_r[3]};
  assign pend = flags & enables;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid && wstrb0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (aw_held_r && w_held_r && !s_axi_bvalid) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_r)
          ADDR_CTRL_A, ADDR_TIMER, ADDR_TBASE, ADDR_GLOBAL,
          ADDR_EV_STATUS, ADDR_EV_CLEAR, ADDR_EV_ENABLE:
            s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode; lane 1 feeds only event bits 9:8, higher byte lanes hold no storage
  assign wr_a = wr_go && awaddr_r == ADDR_CTRL_A;
  assign wr_b = wr_go && awaddr_r == ADDR_TIMER;
  assign wr_c = wr_go && awaddr_r == ADDR_TBASE;
  assign wr_g = wr_go && awaddr_r == ADDR_GLOBAL;
  assign wr_clr = wr_go && awaddr_r == ADDR_EV_CLEAR;
  assign wr_en = wr_go && awaddr_r == ADDR_EV_ENABLE;

  // hardware set and service clear masks per register
  assign svc_clr = core_ack.ack ? onehot(core_ack.src) : RST_SRC;
  assign set_a = nib_mask(src_event[3:0]);
  assign set_b = nib_mask(src_event[7:4]);
  assign set_c = {2'b00, src_event[9], src_event[8], 4'h0};
  assign clr_a = nib_mask(svc_clr[3:0]);
  assign clr_b = nib_mask(svc_clr[7:4]);
  assign clr_c = {2'b00, svc_clr[9], svc_clr[8], 4'h0};

  // software write, then service clear, then event set: a set never lost
  always_comb begin
    ctrl_a_nxt = wr_a ? wdata_r[7:0] : ctrl_a_r;
    timer_nxt = wr_b ? wdata_r[7:0] : timer_r;
    tbase_nxt = wr_c ? (wdata_r[7:0] & TB_IMPL_MASK) : tbase_r;
    ctrl_a_nxt = (ctrl_a_nxt & ~clr_a) | set_a;
    timer_nxt = (timer_nxt & ~clr_b) | set_b;
    tbase_nxt = (tbase_nxt & ~clr_c) | set_c;
  end

  // control registers, all zero after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_r <= RST_REG8;
      timer_r <= RST_REG8;
      tbase_r <= RST_REG8;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      timer_r <= timer_nxt;
      tbase_r <= tbase_nxt;
    end
  end

  // global enable: service wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_r <= 1'b0;
    end else if (core_ack.ack) begin
      gie_r <= 1'b0;
    end else if (wr_g) begin
      gie_r <= wdata_r[GLOBAL_EN_BIT];
    end
  end

  // highest priority enabled request toward the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_req_r <= '0;
    end else begin
      core_req_r.req <= gie_r && !core_ack.ack && |pend;
      core_req_r.src <= '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (pend[i]) begin
          core_req_r.src <= 4'(i);
        end
      end
    end
  end
  assign core_req = core_req_r;

  // wake on any flag going from clear to set, even when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= |((ctrl_a_nxt & ~ctrl_a_r & 8'hF0) |
                  (timer_nxt & ~timer_r & 8'hF0) |
                  (tbase_nxt & ~tbase_r & 8'h30));
    end
  end
  assign wake = wake_r;

  // sticky event status: set beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_status_r <= RST_SRC;
      ev_enable_r <= RST_SRC;
    end else begin
      ev_status_r <= (ev_status_r & ~(wr_clr ? wdata_r[NUM_SRC-1:0] :
                      RST_SRC)) | src_event;
      if (wr_en) begin
        ev_enable_r <= wdata_r[NUM_SRC-1:0];
      end
    end
  end
  assign irq = |(ev_status_r & ev_enable_r);

  // read channel, one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      unique case (s_axi_araddr)
        ADDR_CTRL_A: s_axi_rdata[7:0] <= ctrl_a_r;
        ADDR_TIMER: s_axi_rdata[7:0] <= timer_r;
        ADDR_TBASE: s_axi_rdata[7:0] <= tbase_r & TB_IMPL_MASK;
        ADDR_GLOBAL: s_axi_rdata[GLOBAL_EN_BIT] <= gie_r;
        ADDR_EV_STATUS: s_axi_rdata[NUM_SRC-1:0] <= ev_status_r;
        ADDR_EV_CLEAR: s_axi_rdata <= '0; // write-only
        ADDR_EV_ENABLE: s_axi_rdata[NUM_SRC-1:0] <= ev_enable_r;
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_eeprom_flag_set: assert property (
    src_event[SRC_EEPROM] |=> ctrl_a_r[7])
    else $error("eeprom event did not set its flag");
  a_std_a_set: assert property (
    src_event[SRC_STD_A] |=> timer_r[7])
    else $error("std timer A event did not set flag");
  a_per_a_set: assert property (
    src_event[SRC_PER_A] |=> timer_r[5])
    else $error("periodic timer A event did not set flag");
  a_tbase_one_set: assert property (
    src_event[SRC_TB_ONE] |=> tbase_r[5])
    else $error("time base one event did not set flag");
  a_tbase_zero_set: assert property (
    src_event[SRC_TB_ZERO] |=> tbase_r[4])
    else $error("time base zero event did not set flag");
  a_tbase_unimpl_zero: assert property (
    s_axi_rvalid && $past(s_axi_araddr == ADDR_TBASE && s_axi_arready
      && s_axi_arvalid) |-> s_axi_rdata[7] == 1'b0 &&
      s_axi_rdata[3] == 1'b0)
    else $error("unimplemented time base bits read nonzero");
  // index the previous pending set with the source shown now
  a_enable_gates_req: assert property (
    core_req.req |-> ($past(pend) & onehot(core_req.src)) != RST_SRC)
    else $error("request raised for a disabled or clear source");
  a_global_blocks: assert property (
    !gie_r ##1 !gie_r |-> !core_req.req)
    else $error("request raised with global enable low");
  a_service_blocks: assert property (
    core_ack.ack |=> !gie_r ##1 !core_req.req)
    else $error("service did not clear global enable");
  a_wake_on_set: assert property (
    $rose(ctrl_a_r[7]) || $rose(timer_r[5]) || $rose(tbase_r[4])
      |-> wake_r)
    else $error("newly set flag did not wake the core");
  a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> ctrl_a_r == RST_REG8 && timer_r == RST_REG8 &&
      tbase_r == RST_REG8 && !gie_r)
    else $error("registers not cleared by reset");
  a_write_resp_once: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  a_serial_enable: assert property (
    core_req.req && core_req.src == SRC_SERIAL |-> $past(ctrl_a_r[0]))
    else $error("serial request raised with its enable low");
  a_service_clears_flag: assert property (
    core_ack.ack && core_ack.src == SRC_STD_A && !src_event[SRC_STD_A]
      && !wr_b |=> !timer_r[7])
    else $error("serviced std timer A flag not cleared");

  c_service: cover property (core_req.req ##[1:4] core_ack.ack);
  c_wake: cover property (wake_r);
  c_irq_out: cover property (irq ##1 wr_clr);
  c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule : pfe_irq_flags

//--- pfe_core_model.sv
`timescale 1ns/1ps
module pfe_core_model
  import pfe_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cycles to wait before taking a pending request
  input wire logic [1:0] delay,
  // request in, service acknowledge out
  input wire pfe_core_req_type core_req,
  output pfe_core_ack_type core_ack
);
  logic [2:0] wait_r;

  // one-cycle acknowledge after a variable wait; never twice per request
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_req.req || core_ack.ack) begin
      wait_r <= 3'h0;
      core_ack <= '0;
    end else if (wait_r == {1'h0, delay}) begin
      core_ack.ack <= 1'h1;
      core_ack.src <= core_req.src;
    end else begin
      wait_r <= wait_r + 3'h1;
    end
  end
endmodule : pfe_core_model

//--- peripheral_irq_flag_enable_tb.sv
`timescale 1ns/1ps
module peripheral_irq_flag_enable_tb;
  import pfe_pkg::*;
  // bus, event and core signals; only those the bench drives are defined at time zero
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, wake, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] delay = 2'h0;
  logic [NUM_SRC-1:0] src_event = 10'h000;
  pfe_core_req_type core_req;
  pfe_core_ack_type core_ack;
  logic [33:0] exp_q[$];
  int bad_count = 0, comparisons = 0, cycles = 0, seed = 83178;

  pfe_irq_flags i_pfe_irq_flags (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .src_event, .core_req, .core_ack, .wake, .irq);
  pfe_core_model i_pfe_core_model (.aclk, .aresetn, .delay, .core_req,
    .core_ack);

  initial forever #4 aclk = ~aclk;

  task automatic chk(input string n, input logic [33:0] e, s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // a hang is cut short well above the expected run length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // read results are matched against the oldest note
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});

  // handshakes are judged on the rising edge that takes them; each valid
  // and its payload stand until then, and are released by nba after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin
        ta = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    chk("bresp", r, s_axi_bresp);
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic pulse(input int i);
    @(posedge aclk);
    src_event <= 10'h001 << i;
    @(posedge aclk);
    src_event <= 10'h000;
  endtask : pulse

  // main sequence
  initial begin
    logic [7:0] a;
    logic [31:0] v;
    int fb, n;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 7; k++) rd(8'(k * 4), 0);
    rd(8'h1C, 0, RESP_SLVERR);
    wr(8'h1C, 32'h0000_00FF, RESP_SLVERR);
    // reserved bits kept zero, absent bits written as ones
    for (int k = 0; k < 9; k++) begin
      a = 8'(k % 3 * 4);
      v = k < 3 ? 32'hFFFF_FFFF : $random(seed);
      if (a == ADDR_TBASE) v = (v | 32'h88) & 32'hBB;
      wr(a, v & 32'hFF);
      rd(a, a == ADDR_TBASE ? v & 32'h33 : v & 32'hFF);
    end
    for (int k = 0; k < 3; k++) wr(8'(k * 4), 0);
    // lane 0 off: the write is answered but leaves the register alone
    s_axi_wstrb <= 4'h0;
    wr(ADDR_CTRL_A, 32'h0000_00FF);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_CTRL_A, 0);
    // every source: record, mask, request, service, record while blocked
    for (int i = 0; i < NUM_SRC; i++) begin
      a = i < 4 ? ADDR_CTRL_A : i < 8 ? ADDR_TIMER : ADDR_TBASE;
      fb = i < 8 ? 7 - i % 4 : i - 4;
      delay <= 2'(i % 3);
      wr(ADDR_GLOBAL, 1);
      pulse(i);
      @(negedge aclk);
      chk("wake", 1, wake);
      @(negedge aclk);
      chk("wake", 0, wake);
      chk("req", 0, core_req.req);
      rd(a, 1 << fb);
      wr(a, (1 << fb) | (1 << (fb - 4)));
      n = 0;
      while (!core_ack.ack && n < 20) begin
        @(negedge aclk);
        n++;
      end
      chk("ack", 1, core_ack.ack);
      chk("src", i, core_ack.src);
      @(negedge aclk);
      chk("req", 0, core_req.req);
      rd(ADDR_GLOBAL, 0);
      rd(a, 1 << (fb - 4));
      pulse(i);
      repeat (2) @(negedge aclk);
      chk("req", 0, core_req.req);
      rd(a, (1 << fb) | (1 << (fb - 4)));
      wr(a, 0);
    end
    // summary interrupt: latch, enable, clear, mask
    rd(ADDR_EV_STATUS, 32'h0000_03FF);
    chk("irq", 0, irq);
    wr(ADDR_EV_ENABLE, 32'h0000_0008);
    @(negedge aclk);
    chk("irq", 1, irq);
    wr(ADDR_EV_CLEAR, 32'h0000_03FF);
    @(negedge aclk);
    chk("irq", 0, irq);
    rd(ADDR_EV_STATUS, 0);
    rd(ADDR_EV_CLEAR, 0);
    pulse(0);
    repeat (2) @(negedge aclk);
    chk("irq", 0, irq);
    pulse(3);
    repeat (2) @(negedge aclk);
    chk("irq", 1, irq);
    rd(ADDR_EV_ENABLE, 32'h0000_0008);
    end_sim();
  end
endmodule : peripheral_irq_flag_enable_tb
